// >>> pkg/gcc_consts.svh
// gcc_consts.svh: offsets, field positions, reset values and counts
// for the gated counter control block.
// assumes: included by bare name from the package and the design file.
`ifndef GCC_CONSTS_SVH
`define GCC_CONSTS_SVH

// register offsets on the plain register port (4-bit address)
`define GCC_OFF_CTRL        4'h0
`define GCC_OFF_GATE_CTRL   4'h1
`define GCC_OFF_FLAG        4'h2
`define GCC_OFF_ENABLE      4'h3

// counter_control fields
`define GCC_CS_MSB          7
`define GCC_CS_LSB          6
`define GCC_PS_MSB          5
`define GCC_PS_LSB          4
`define GCC_OSC_EN_BIT      3
`define GCC_SYNC_BYP_BIT    2
`define GCC_RUN_BIT         0
`define GCC_CTRL_WMASK      8'hFD
`define GCC_CTRL_RESET      8'h00

// clock source codes
`define GCC_CS_SYS_DIV4     2'h0
`define GCC_CS_SYS          2'h1
`define GCC_CS_PIN_OSC      2'h2
`define GCC_CS_CAP_OSC      2'h3

// gate_control_register fields
`define GCC_GE_BIT          7
`define GCC_GPOL_BIT        6
`define GCC_GTM_BIT         5
`define GCC_GSPM_BIT        4
`define GCC_GARM_BIT        3
`define GCC_GVAL_BIT        2

// flag and enable registers: gate event in bit 0
`define GCC_GEV_BIT         0

// input synchroniser lanes
`define GCC_NUM_IN          4
`define GCC_IN_GATE         0
`define GCC_IN_EXT_CLK      1
`define GCC_IN_CRYSTAL      2
`define GCC_IN_CAP_OSC      3

// system clock divided by four: terminal count of the divider
`define GCC_DIV4_LAST       2'h3

`endif

// >>> pkg/gcc_pkg.sv
// gcc_pkg.sv: types shared by the gated counter control block.
// assumes: gcc_consts.svh sits beside it on the include path.
`include "gcc_consts.svh"

package gcc_pkg;

    // single-pulse capture sequence
    typedef enum logic [1:0]
    {
        GCC_SP_IDLE,
        GCC_SP_ARMED,
        GCC_SP_OPEN
    } gcc_sp_e;

    // register-port request, one cycle long
    typedef struct packed
    {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } gcc_req_s;

    // all state of the control block
    typedef struct packed
    {
        logic [7:0]               ctrl;
        logic                     gate_en;
        logic                     gate_pol;
        logic                     tog_en;
        logic                     sp_en;
        gcc_sp_e                  sp;
        logic                     tff;
        logic                     tog_prev;
        logic                     gval;
        logic                     flag;
        logic                     mask;
        logic [`GCC_NUM_IN-1:0]   sync1;
        logic [`GCC_NUM_IN-1:0]   sync2;
        logic [`GCC_NUM_IN-1:0]   sync3;
        logic [`GCC_NUM_IN-1:0]   filt;
        logic                     ext_align;
        logic [1:0]               div4;
        logic [2:0]               pcnt;
        logic                     tick;
        logic                     irq;
        logic [7:0]               rdata;
    } gcc_state_s;

endpackage : gcc_pkg

// >>> hw/gcc_gate_ctrl.sv
// gcc_gate_ctrl.sv: gate toggle, single-pulse capture, gate status,
// gate event interrupt, clock select, prescaler and run control.
// assumes: one 25 MHz core clock; gate and clock pins are asynchronous
// and are sampled here; the counter datapath sits outside and advances
// by one on each count_tick_out pulse.
`include "gcc_consts.svh"

// Notes on behaviour
// (RQ1) toggle mode routes gate through a flip-flop flipping on each active edge
// (RQ2) toggle enable clear forces and holds the toggle flip-flop at zero
// (RQ3) single-pulse: enable, then arm; window opens at next active gate edge
// (RQ4) arm clears itself on the trailing edge; later gate events are ignored
// (RQ5) clearing single-pulse enable clears the arm bit at once
// (RQ6) toggle plus single-pulse together capture one full gate cycle
// (RQ7) software should not enable toggle while changing gate polarity
// (RQ8) gate level status is readable and valid with gate control off
// (RQ9) falling edge of gate level status sets the gate event flag
// (RQ10) gate event interrupt raised only while flag and its enable are set
// (RQ11) gate event flag keeps working with gate control disabled
// (RQ12) clock source field: capacitive osc, pin/osc, system, system/4
// (RQ13) source pin/osc: external pin rising edges, or crystal when osc on
// (RQ14) prescale field divides input clock by 1, 2, 4 or 8
// (RQ15) control bit 3 switches the dedicated oscillator on or off
// (RQ16) bit 2 bypasses or applies input synchronisation for 1x sources
// (RQ17) control bit 1 is unimplemented and reads zero
// (RQ18) run bit lets the counter advance; all control bits reset to zero
module gcc_gate_ctrl
    import gcc_pkg::*;
(
    input  wire logic       core_clk_in,
    input  wire logic       rst_in,
    input  wire logic [3:0] addr_in,
    input  wire logic [7:0] wr_data_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    input  wire logic       gate_pin_in,
    input  wire logic       ext_clock_pin_in,
    input  wire logic       crystal_pins_in,
    input  wire logic       cap_osc_in,
    output logic [7:0]      rd_data_out,
    output logic            count_tick_out,
    output logic            dedicated_osc_enable_out,
    output logic            irq_out
);

    gcc_state_s              state_reg;
    gcc_state_s              state_next;
    gcc_req_s                req;
    logic [`GCC_NUM_IN-1:0]  filt_next;
    logic [`GCC_NUM_IN-1:0]  rise;
    logic [1:0]              clk_src;
    logic [1:0]              pre_sel;
    logic                    run;
    logic                    gate_lvl;
    logic                    gate_rise;
    logic                    tog_out;
    logic                    tog_rise;
    logic                    tog_fall;
    logic                    ext_raw;
    logic                    src_tick;
    logic [2:0]              pre_mask;
    logic                    pre_hit;
    logic                    wr_gate;

    // bus signals grouped for the decode below
    assign req.wr    = wr_in;
    assign req.rd    = rd_in;
    assign req.addr  = addr_in;
    assign req.wdata = wr_data_in;
    assign wr_gate   = req.wr && (req.addr == `GCC_OFF_GATE_CTRL);

    // control field views
    assign clk_src = state_reg.ctrl[`GCC_CS_MSB:`GCC_CS_LSB];
    assign pre_sel = state_reg.ctrl[`GCC_PS_MSB:`GCC_PS_LSB];
    assign run     = state_reg.ctrl[`GCC_RUN_BIT];

    // per-input filter: a change counts once stages two and three agree,
    // so a pin caught mid-transition cannot make a spurious edge
    genvar gi;
    generate
        for (gi = 0; gi < `GCC_NUM_IN; gi++)
        begin : g_filt
            assign filt_next[gi] =
                (state_reg.sync2[gi] == state_reg.sync3[gi]) ?
                state_reg.sync3[gi] : state_reg.filt[gi];
            assign rise[gi] = filt_next[gi] & ~state_reg.filt[gi];
        end
    endgenerate

    // gate polarity: active level is high when the polarity bit is set
    assign gate_lvl  = state_reg.gate_pol ? filt_next[`GCC_IN_GATE]
                                          : ~filt_next[`GCC_IN_GATE];
    assign gate_rise = gate_lvl &
                       ~(state_reg.gate_pol ? state_reg.filt[`GCC_IN_GATE]
                                            : ~state_reg.filt[`GCC_IN_GATE]);

    // toggle stage output and its edges, one cycle after the gate in toggle mode, same cycle otherwise
    assign tog_out  = state_reg.tog_en ? state_reg.tff : gate_lvl; // [RQ1]
    assign tog_rise = tog_out & ~state_reg.tog_prev;
    assign tog_fall = ~tog_out & state_reg.tog_prev;

    // source 1x: capacitive osc when selected, else crystal when the oscillator is on, else the pin
    always_comb
    begin
        if (clk_src == `GCC_CS_CAP_OSC)
        begin
            ext_raw = rise[`GCC_IN_CAP_OSC]; // [RQ12]
        end
        else if (state_reg.ctrl[`GCC_OSC_EN_BIT])
        begin
            ext_raw = rise[`GCC_IN_CRYSTAL]; // [RQ13]
        end
        else
        begin
            ext_raw = rise[`GCC_IN_EXT_CLK]; // [RQ13]
        end
    end

    // clock source pick; sync bit only matters for sources 1x
    always_comb
    begin
        unique case (clk_src)
            `GCC_CS_SYS_DIV4: src_tick = (state_reg.div4 == `GCC_DIV4_LAST);
            `GCC_CS_SYS:      src_tick = 1'b1;
            `GCC_CS_PIN_OSC,
            `GCC_CS_CAP_OSC:  src_tick =
                state_reg.ctrl[`GCC_SYNC_BYP_BIT] ? ext_raw   // [RQ16]
                                                  : state_reg.ext_align;
        endcase
    end

    // prescaler mask: divide by 1, 2, 4 or 8
    always_comb
    begin
        unique case (pre_sel)
            2'h0: pre_mask = 3'h0;
            2'h1: pre_mask = 3'h1;
            2'h2: pre_mask = 3'h3;
            2'h3: pre_mask = 3'h7;
        endcase
    end
    assign pre_hit = ((state_reg.pcnt & pre_mask) == pre_mask); // [RQ14]

    // next-state logic for the whole block
    always_comb
    begin
        state_next = state_reg;

        // three-stage pin synchronisers
        state_next.sync1 = {cap_osc_in, crystal_pins_in,
                            ext_clock_pin_in, gate_pin_in};
        state_next.sync2 = state_reg.sync1;
        state_next.sync3 = state_reg.sync2;
        state_next.filt  = filt_next;

        // synchronised path costs one extra system clock of latency
        state_next.ext_align = ext_raw; // [RQ16]
        state_next.div4      = state_reg.div4 + 2'h1;

        // prescaler advances on source ticks while running
        if (!run)
        begin
            state_next.pcnt = 3'h0;
        end
        else if (src_tick)
        begin
            state_next.pcnt = state_reg.pcnt + 3'h1; // [RQ14]
        end

        // toggle flip-flop: flips on active edges, held clear when off
        if (!state_reg.tog_en)
        begin
            state_next.tff = 1'b0; // [RQ2]
        end
        else if (gate_rise)
        begin
            state_next.tff = ~state_reg.tff; // [RQ1]
        end
        state_next.tog_prev = tog_out;

        // single-pulse sequence; the toggle output feeds it so both
        // modes together frame one whole gate period
        unique case (state_reg.sp)
            GCC_SP_IDLE:
                state_next.sp = GCC_SP_IDLE;
            GCC_SP_ARMED:
                if (tog_rise)
                begin
                    state_next.sp = GCC_SP_OPEN; // [RQ3] [RQ6]
                end
            GCC_SP_OPEN:
                if (tog_fall)
                begin
                    state_next.sp = GCC_SP_IDLE; // [RQ4]
                end
        endcase
        if (!state_reg.sp_en)
        begin
            state_next.sp = GCC_SP_IDLE; // [RQ5]
        end

        // gate level status follows the gating value in every mode
        state_next.gval = state_reg.sp_en ?
                          (state_reg.sp == GCC_SP_OPEN) : tog_out; // [RQ8]

        // register writes
        if (req.wr)
        begin
            unique case (req.addr)
                `GCC_OFF_CTRL:
                begin
                    state_next.ctrl = req.wdata & `GCC_CTRL_WMASK; // [RQ17]
                    state_next.pcnt = 3'h0;
                end
                `GCC_OFF_GATE_CTRL:
                begin
                    state_next.gate_en  = req.wdata[`GCC_GE_BIT];
                    state_next.gate_pol = req.wdata[`GCC_GPOL_BIT];
                    state_next.tog_en   = req.wdata[`GCC_GTM_BIT];
                    state_next.sp_en    = req.wdata[`GCC_GSPM_BIT];
                    // arming needs single-pulse on; a zero write leaves it
                    if (!req.wdata[`GCC_GSPM_BIT])
                    begin
                        state_next.sp = GCC_SP_IDLE; // [RQ5]
                    end
                    else if (req.wdata[`GCC_GARM_BIT] &&
                             state_reg.sp == GCC_SP_IDLE)
                    begin
                        state_next.sp = GCC_SP_ARMED; // [RQ3]
                    end
                end
                `GCC_OFF_ENABLE:
                    state_next.mask = req.wdata[`GCC_GEV_BIT];
                default:
                    state_next.mask = state_reg.mask;
            endcase
        end

        // read data, valid the cycle after the strobe; unmapped reads zero
        state_next.rdata = 8'h00;
        if (req.rd)
        begin
            unique case (req.addr)
                `GCC_OFF_CTRL:
                    state_next.rdata = state_reg.ctrl; // [RQ17]
                `GCC_OFF_GATE_CTRL:
                begin
                    state_next.rdata[`GCC_GE_BIT]   = state_reg.gate_en;
                    state_next.rdata[`GCC_GPOL_BIT] = state_reg.gate_pol;
                    state_next.rdata[`GCC_GTM_BIT]  = state_reg.tog_en;
                    state_next.rdata[`GCC_GSPM_BIT] = state_reg.sp_en;
                    state_next.rdata[`GCC_GARM_BIT] =
                        (state_reg.sp != GCC_SP_IDLE);
                    state_next.rdata[`GCC_GVAL_BIT] = state_reg.gval; // [RQ8]
                end
                `GCC_OFF_FLAG:
                    state_next.rdata[`GCC_GEV_BIT] = state_reg.flag;
                `GCC_OFF_ENABLE:
                    state_next.rdata[`GCC_GEV_BIT] = state_reg.mask;
                default:
                    state_next.rdata = 8'h00;
            endcase
        end

        // flag: read clears it, but a falling gate status in the same
        // cycle wins so no event is lost; gate enable plays no part
        if (req.rd && req.addr == `GCC_OFF_FLAG)
        begin
            state_next.flag = 1'b0;
        end
        if (state_reg.gval && !state_next.gval)
        begin
            state_next.flag = 1'b1; // [RQ9] [RQ11]
        end

        // level interrupt, taken from next values so it tracks the flag
        state_next.irq = state_next.flag & state_next.mask; // [RQ10]

        // count enable: running, prescaler hit, and gate open if gated
        state_next.tick = run && src_tick && pre_hit &&
                          (!state_reg.gate_en || state_reg.gval); // [RQ18]
    end

    // state register; everything resets to zero
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_reg <= '0; // [RQ18]
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // outputs straight from flops
    assign rd_data_out              = state_reg.rdata;
    assign count_tick_out           = state_reg.tick;
    assign dedicated_osc_enable_out = state_reg.ctrl[`GCC_OSC_EN_BIT]; // [RQ15]
    assign irq_out                  = state_reg.irq;

    // checks on the block's own behaviour
    sequence s_armed_edge;
        state_reg.sp == GCC_SP_ARMED && state_reg.sp_en && tog_rise;
    endsequence

    sequence s_open_trail;
        state_reg.sp == GCC_SP_OPEN && state_reg.sp_en && tog_fall;
    endsequence

    sequence s_sys_run;
        run && clk_src == `GCC_CS_SYS && pre_sel == 2'h0 &&
        !state_reg.gate_en;
    endsequence

    toggle_flip_a: assert property ( // [RQ1]
        @(posedge core_clk_in) disable iff (rst_in)
        state_reg.tog_en && gate_rise |=> state_reg.tff != $past(state_reg.tff))
        else $error("toggle flip-flop missed an active gate edge");

    toggle_hold_a: assert property ( // [RQ2]
        @(posedge core_clk_in) disable iff (rst_in)
        !state_reg.tog_en |=> !state_reg.tff)
        else $error("toggle flip-flop not held clear");

    pulse_open_a: assert property ( // [RQ3]
        @(posedge core_clk_in) disable iff (rst_in)
        s_armed_edge |=> state_reg.sp == GCC_SP_OPEN ##1 state_reg.gval)
        else $error("single-pulse window failed to open");

    pulse_done_a: assert property ( // [RQ4]
        @(posedge core_clk_in) disable iff (rst_in)
        s_open_trail |=> state_reg.sp == GCC_SP_IDLE ##1
        (state_reg.sp != GCC_SP_OPEN))
        else $error("arm bit not cleared on trailing edge");

    spm_clear_a: assert property ( // [RQ5]
        @(posedge core_clk_in) disable iff (rst_in)
        wr_gate && !req.wdata[`GCC_GSPM_BIT] |=> state_reg.sp == GCC_SP_IDLE)
        else $error("arm bit survived single-pulse disable");

    flag_set_a: assert property ( // [RQ9] [RQ11]
        @(posedge core_clk_in) disable iff (rst_in)
        $fell(state_reg.gval) |-> state_reg.flag)
        else $error("gate event flag not set on falling status");

    irq_level_a: assert property ( // [RQ10]
        @(posedge core_clk_in) disable iff (rst_in)
        $rose(state_reg.flag) && state_reg.mask |-> irq_out ##1
        (irq_out || !state_reg.flag || !state_reg.mask))
        else $error("interrupt not raised for enabled flag");

    sys_clock_a: assert property ( // [RQ12]
        @(posedge core_clk_in) disable iff (rst_in)
        s_sys_run ##1 s_sys_run |-> count_tick_out)
        else $error("system clock source did not count");

    ctrl_bit1_a: assert property ( // [RQ17]
        @(posedge core_clk_in) disable iff (rst_in)
        req.rd && req.addr == `GCC_OFF_CTRL |=> !rd_data_out[1])
        else $error("unimplemented control bit read as one");

    run_stop_a: assert property ( // [RQ18]
        @(posedge core_clk_in) disable iff (rst_in)
        !run |=> !count_tick_out)
        else $error("counter ticked while stopped");

endmodule : gcc_gate_ctrl

// >>> dv/gcc_pin_model.sv
// gcc_pin_model.sv: far-side model of the gate pin and clock source pins.
// assumes: the bench moves the gate through set_gate; oscillators run free
// and are unrelated in phase to the core clock.
module gcc_pin_model
#(
    parameter int EXT_HALF_NS  = 150,
    parameter int XTAL_HALF_NS = 230,
    parameter int CAP_HALF_NS  = 190
)
(
    output logic gate_out,
    output logic ext_clk_out,
    output logic crystal_out,
    output logic cap_osc_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // all pins start low so the core sees no edge at reset; sources start
    // half a ns late so no pin ever moves in a core clock edge's time step
    initial
    begin
        gate_out    = 1'b0;
        ext_clk_out = 1'b0;
        crystal_out = 1'b0;
        cap_osc_out = 1'b0;
        #0.5;
        // free-running sources; distinct rates show which one is selected
        fork
            forever #(EXT_HALF_NS) ext_clk_out = ~ext_clk_out;
            forever #(XTAL_HALF_NS) crystal_out = ~crystal_out;
            forever #(CAP_HALF_NS) cap_osc_out = ~cap_osc_out;
        join_none
    end

    // gate moves a few ns off the caller's edge, as a real async pin would
    task automatic set_gate(input logic v);
        #13 gate_out = v;
    endtask : set_gate
endmodule : gcc_pin_model

// >>> dv/gated_counter_gate_and_clock_control_tb_top.sv
// tb top: self-checking bench for the gated counter control block.
// assumes: gcc_consts.svh on the include path; pins come from the model.
`include "gcc_consts.svh"

`define GCC_CHK(what, exp, got) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got); \
        end \
    end

module gated_counter_gate_and_clock_control_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import gcc_pkg::*;

    logic       core_clk_in;
    logic       rst_in;
    logic [3:0] addr_in;
    logic [7:0] wr_data_in;
    logic       wr_in;
    logic       rd_in;
    logic       gate_pin;
    logic       ext_pin;
    logic       xtal_pin;
    logic       cap_pin;
    logic [7:0] rd_data_out;
    logic       count_tick_out;
    logic       osc_en;
    logic       irq_out;
    int         mismatches = 0;
    int         cmp_count  = 0;
    int         tick_total = 0;
    int         ext_n      = 0;
    int         xtal_n     = 0;
    int         cap_n      = 0;

    gcc_gate_ctrl gcc_gate_ctrl_i (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
        .gate_pin_in(gate_pin), .ext_clock_pin_in(ext_pin),
        .crystal_pins_in(xtal_pin), .cap_osc_in(cap_pin),
        .rd_data_out(rd_data_out), .count_tick_out(count_tick_out),
        .dedicated_osc_enable_out(osc_en), .irq_out(irq_out));

    gcc_pin_model gcc_pin_model_i (
        .gate_out(gate_pin), .ext_clk_out(ext_pin),
        .crystal_out(xtal_pin), .cap_osc_out(cap_pin));

    // clock, 40 ns period
    always #20 core_clk_in = ~core_clk_in;

    // running totals let a window be measured by two snapshots
    always @(posedge core_clk_in) if (count_tick_out === 1'b1) tick_total++;
    always @(posedge ext_pin) ext_n++;
    always @(posedge xtal_pin) xtal_n++;
    always @(posedge cap_pin) cap_n++;

    task automatic close_out;
        if (mismatches == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask : cycles

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        addr_in    <= a;
        wr_data_in <= d;
        wr_in      <= 1'b1;
        @(posedge core_clk_in);
        wr_in <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic chk_reg(input string what, input logic [3:0] a,
                           input logic [7:0] mask, input logic [7:0] exp);
        logic [7:0] d;
        @(posedge core_clk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge core_clk_in);
        rd_in <= 1'b0;
        #1 d = rd_data_out;
        `GCC_CHK(what, exp, d & mask)
    endtask : chk_reg

    task automatic ticks(input int n, output int c);
        int t0;
        cycles(1);
        #1 t0 = tick_total;
        cycles(n);
        #1 c = tick_total - t0;
    endtask : ticks

    // filtered gate lags the pin by about four cycles; ten is safe
    task automatic gate(input logic v, input int n);
        gcc_pin_model_i.set_gate(v);
        cycles(n);
    endtask : gate

    function automatic int edges(input logic [7:0] c);
        if (c[7:6] == `GCC_CS_CAP_OSC)
            return cap_n;
        return c[3] ? xtal_n : ext_n;
    endfunction : edges

    task automatic t_reset;
        chk_reg("ctrl rst", `GCC_OFF_CTRL, 8'hFF, 8'h00);
        chk_reg("gate rst", `GCC_OFF_GATE_CTRL, 8'hFB, 8'h00);
        chk_reg("flag rst", `GCC_OFF_FLAG, 8'hFF, 8'h00);
        chk_reg("en rst", `GCC_OFF_ENABLE, 8'hFF, 8'h00);
        wr_reg(4'h9, 8'hFF);
        chk_reg("unmapped", 4'h9, 8'hFF, 8'h00);
        wr_reg(`GCC_OFF_CTRL, 8'hFF);
        chk_reg("ctrl bit1", `GCC_OFF_CTRL, 8'hFF, 8'hFD);
        `GCC_CHK("osc on", 1'b1, osc_en)
        wr_reg(`GCC_OFF_CTRL, 8'h00);
        cycles(2);
        `GCC_CHK("osc off", 1'b0, osc_en)
    endtask : t_reset

    // windows are whole multiples of every tick period, so counts are exact
    task automatic t_prescale;
        int c;
        for (int s = 0; s < 2; s++)
            for (int p = 0; p < 4; p++)
            begin
                wr_reg(`GCC_OFF_CTRL, {s[1:0], p[1:0], 4'h5});
                cycles(8);
                ticks(96, c);
                `GCC_CHK("div", 96 / ((s == 0 ? 4 : 1) << p), c)
                `GCC_CHK("src", 96 / ((s == 0 ? 4 : 1) << p), c)
            end
        wr_reg(`GCC_OFF_CTRL, 8'h40);
        ticks(40, c);
        `GCC_CHK("run off", 0, c)
    endtask : t_prescale

    // async sources: the count may differ by the pipeline's edge or two
    task automatic t_pins;
        logic [7:0] cfg [4] = '{8'h81, 8'h85, 8'h89, 8'hC1};
        int         c;
        int         e0;
        for (int i = 0; i < 4; i++)
        begin
            wr_reg(`GCC_OFF_CTRL, cfg[i]);
            cycles(10);
            e0 = edges(cfg[i]);
            ticks(200, c);
            e0 = edges(cfg[i]) - e0;
            `GCC_CHK("pin", 1'b1, (c >= e0 - 2) && (c <= e0 + 2))
            `GCC_CHK("sync", 1'b1, (c > 10))
            `GCC_CHK("osc", cfg[i][3], osc_en)
        end
    endtask : t_pins

    task automatic t_gate;
        wr_reg(`GCC_OFF_CTRL, 8'h41);
        wr_reg(`GCC_OFF_GATE_CTRL, 8'h40); // polarity alone first
        gate(1'b1, 10);
        chk_reg("level hi", `GCC_OFF_GATE_CTRL, 8'h04, 8'h04);
        // polarity flip with the pin low made the status fall once
        chk_reg("flag pol", `GCC_OFF_FLAG, 8'h01, 8'h01);
        gate(1'b0, 10);
        chk_reg("level lo", `GCC_OFF_GATE_CTRL, 8'h04, 8'h00);
        `GCC_CHK("irq masked", 1'b0, irq_out)
        wr_reg(`GCC_OFF_ENABLE, 8'h01);
        cycles(2);
        `GCC_CHK("irq up", 1'b1, irq_out)
        chk_reg("flag set", `GCC_OFF_FLAG, 8'h01, 8'h01);
        cycles(2);
        `GCC_CHK("irq down", 1'b0, irq_out)
        chk_reg("flag clr", `GCC_OFF_FLAG, 8'h01, 8'h00);
        wr_reg(`GCC_OFF_ENABLE, 8'h00);
    endtask : t_gate

    task automatic t_toggle;
        int c;
        wr_reg(`GCC_OFF_GATE_CTRL, 8'hE0); // polarity unchanged
        gate(1'b1, 10);
        gate(1'b0, 10);
        chk_reg("tog hi", `GCC_OFF_GATE_CTRL, 8'h04, 8'h04);
        ticks(20, c);
        `GCC_CHK("tog open", 20, c)
        gate(1'b1, 10);
        gate(1'b0, 10);
        ticks(20, c);
        `GCC_CHK("tog shut", 0, c)
        gate(1'b1, 10);
        gate(1'b0, 10);
        // leaving and re-entering toggle must drop the stored high state
        wr_reg(`GCC_OFF_GATE_CTRL, 8'hC0);
        wr_reg(`GCC_OFF_GATE_CTRL, 8'hE0);
        cycles(8);
        chk_reg("tog held", `GCC_OFF_GATE_CTRL, 8'h04, 8'h00);
        ticks(20, c);
        `GCC_CHK("tog zero", 0, c)
    endtask : t_toggle

    task automatic t_single;
        int c;
        wr_reg(`GCC_OFF_GATE_CTRL, 8'hD0);
        wr_reg(`GCC_OFF_GATE_CTRL, 8'hD8);
        chk_reg("armed", `GCC_OFF_GATE_CTRL, 8'h08, 8'h08);
        ticks(20, c);
        `GCC_CHK("sp wait", 0, c)
        gate(1'b1, 10);
        ticks(20, c);
        `GCC_CHK("sp open", 20, c)
        gate(1'b0, 10);
        chk_reg("sp done", `GCC_OFF_GATE_CTRL, 8'h08, 8'h00);
        gate(1'b1, 10);
        ticks(20, c);
        `GCC_CHK("sp ignore", 0, c)
        gate(1'b0, 10);
        wr_reg(`GCC_OFF_GATE_CTRL, 8'hD8);
        wr_reg(`GCC_OFF_GATE_CTRL, 8'hC0);
        chk_reg("sp off", `GCC_OFF_GATE_CTRL, 8'h08, 8'h00);
        wr_reg(`GCC_OFF_GATE_CTRL, 8'hF0);
        wr_reg(`GCC_OFF_GATE_CTRL, 8'hF8);
        gate(1'b1, 10);
        gate(1'b0, 10);
        ticks(20, c);
        `GCC_CHK("cycle open", 20, c)
        gate(1'b1, 10);
        chk_reg("cycle done", `GCC_OFF_GATE_CTRL, 8'h08, 8'h00);
        ticks(20, c);
        `GCC_CHK("cycle shut", 0, c)
    endtask : t_single

    // main sequence: reset for five cycles, then each scenario in turn
    initial
    begin
        core_clk_in = 1'b0;
        rst_in      = 1'b1;
        addr_in     = 4'h0;
        wr_data_in  = 8'h00;
        wr_in       = 1'b0;
        rd_in       = 1'b0;
        cycles(5);
        rst_in <= 1'b0;
        t_reset();
        t_prescale();
        t_pins();
        t_gate();
        t_toggle();
        t_single();
        close_out();
    end

    // watchdog: the whole run needs well under ten thousand cycles
    initial
    begin
        cycles(30000);
        mismatches++;
        close_out();
    end
endmodule : gated_counter_gate_and_clock_control_tb_top
